/* logic/ptp_params.svh */
`ifndef PTP_PARAMS_SVH
`define PTP_PARAMS_SVH

// register offsets
`define PTP_ADDR_ISO_CTRL     5'h01
`define PTP_ADDR_TMR_HI       5'h04
`define PTP_ADDR_TMR_LO       5'h05
`define PTP_ADDR_TX_PULSE     5'h06
`define PTP_ADDR_NO_REPLY_TIMEOUT_BITS       5'h07
`define PTP_ADDR_IRQ_STAT     5'h0c
`define PTP_NO_REPLY_TIMEOUT_BITS_FLAG_BIT   0
`define PTP_PROTO_LSB         0

// reset values
`define PTP_RST_ISO_CTRL      8'h07
`define PTP_RST_TX_PULSE      8'h00
`define PTP_RST_NO_REPLY_TIMEOUT_BITS        8'h0e
`define PTP_RST_TMR           14'h0000

// step sizes, tenths of ns
`define PTP_PULSE_STEP_NS10   737
`define PTP_TMR_STEP_NS10     5900
`define PTP_NO_REPLY_TIMEOUT_BITS_STEP_NS10  377600
`define PTP_NS10_TO_REF(x)    (((x) + `PTP_PULSE_STEP_NS10 / 2) / `PTP_PULSE_STEP_NS10)
`define PTP_NO_REPLY_TIMEOUT_BITS_STEP_REF   `PTP_NS10_TO_REF(`PTP_NO_REPLY_TIMEOUT_BITS_STEP_NS10)
`define PTP_TMR_STEP_REF      `PTP_NS10_TO_REF(`PTP_TMR_STEP_NS10)

// default pulse lengths, tenths of ns
`define PTP_PULSE_15693_NS10  94400
`define PTP_PULSE_A106_NS10   23600
`define PTP_PULSE_A212_NS10   14000
`define PTP_PULSE_A424_NS10   7370
`define PTP_PULSE_A848_NS10   4420

// default no-response times, hundredths of us
`define PTP_NO_REPLY_TIMEOUT_BITS_STEP_US100 3776
`define PTP_US100_TO_NR(x)    (((x) + `PTP_NO_REPLY_TIMEOUT_BITS_STEP_US100 / 2) / `PTP_NO_REPLY_TIMEOUT_BITS_STEP_US100)
`define PTP_NR_15693LO_US100  181200
`define PTP_NR_15693HI_US100  75500
`define PTP_NR_OTHER_US100    52900

`endif

/* logic/ptp_pkg.sv */
package ptp_pkg;

    typedef enum logic [2:0] {
        PTP_P15693_LO = 3'h0,
        PTP_P15693_HI = 3'h1,
        PTP_A106      = 3'h2,
        PTP_A212      = 3'h3,
        PTP_A424      = 3'h4,
        PTP_A848      = 3'h5,
        PTP_OTHER     = 3'h7
    } ptp_proto_e;

    typedef enum logic [1:0] {
        PTP_NR_IDLE  = 2'b00,
        PTP_NR_WAIT  = 2'b01,
        PTP_NR_FIRED = 2'b11
    } ptp_nr_state_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } ptp_reg_req_s;

endpackage

/* logic/ptp_step_timer.sv */
module ptp_step_timer
    import ptp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        tick,
    input  wire logic        start,
    input  wire logic        stop,
    input  wire logic [13:0] steps,
    input  wire logic [9:0]  prescale,
    output logic             busy,
    output logic             done
);

    logic [13:0] step_cnt;
    logic [9:0]  pre_cnt;
    logic        last_tick;

    assign last_tick = busy && tick && (pre_cnt == 10'h000) && (step_cnt == 14'h0001);

    // zero steps never starts: timer disabled
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            if (stop)
                busy <= 1'b0;
            else if (start && (steps != 14'h0000))
                busy <= 1'b1;
            else if (last_tick)
            begin
                busy <= 1'b0;
                done <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            step_cnt <= 14'h0000;
            pre_cnt  <= 10'h000;
        end
        else if (ce)
        begin
            if (start && !stop)
            begin
                step_cnt <= steps;
                pre_cnt  <= prescale - 10'h001;
            end
            else if (busy && tick)
            begin
                if (pre_cnt == 10'h000)
                begin
                    pre_cnt  <= prescale - 10'h001;
                    step_cnt <= step_cnt - 14'h0001;
                end
                else
                    pre_cnt <= pre_cnt - 10'h001;
            end
        end
    end

endmodule

/* logic/ptp_timing_regs.sv */
`include "ptp_params.svh"

// Summary of operation
// - pulse register cleared on reset, disable, protocol
// - zero pulse register uses protocol default
// - nonzero pulse register gives value times 73.7ns
// - protocol defaults, 848 kbps ignores override
// - no-response register preset to 0x0e
// - no-response timeout only for 15693
// - timeout raises irq and sets flag
// - no-response value counts 37.76us steps
// - timer starts at slot, stops on response
// - no-response preset per protocol
// - timer length preset to zero
// - timer length counts 590ns, zero disables
module ptp_timing_regs
    import ptp_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         chip_en,
    input  wire logic         ref_clk_in,
    input  wire ptp_reg_req_s reg_req,
    input  wire logic         mod_req,
    input  wire logic         slot_start,
    input  wire logic         rx_start,
    input  wire logic         timer_start,
    output logic [7:0]        reg_rdata,
    output logic              mod_pulse,
    output logic              irq,
    output logic              timer_done
);

    logic [1:0]    pin_s1;
    logic [1:0]    pin_s2;
    logic [1:0]    pin_s3;
    logic [1:0]    pin_lvl;
    logic          en_ok;
    logic          ref_tick;
    logic [7:0]    iso_ctrl;
    logic [7:0]    tx_pulse;
    logic [7:0]    no_reply_timeout_bits;
    logic [13:0]   tmr_len;
    logic          no_reply_timeout_bits_flag;
    ptp_nr_state_e nr_state;
    ptp_nr_state_e next_nr_state;
    ptp_proto_e    proto;
    logic [7:0]    proto_pulse;
    logic [7:0]    proto_no_reply_timeout_bits;
    logic [7:0]    pulse_len;
    logic          iso_wr;
    logic          nr_arm;
    logic          pulse_busy;
    logic          nr_done;
    logic          tmr_done_w;

    // pin synchronisers, change taken when stages 2 and 3 agree
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                begin
                    pin_s1[gi]  <= 1'b0;
                    pin_s2[gi]  <= 1'b0;
                    pin_s3[gi]  <= 1'b0;
                    pin_lvl[gi] <= 1'b0;
                end
                else if (ce)
                begin
                    pin_s1[gi] <= (gi == 0) ? chip_en : ref_clk_in;
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    if (pin_s2[gi] == pin_s3[gi])
                        pin_lvl[gi] <= pin_s3[gi];
                end
            end
        end
    endgenerate

    assign en_ok = pin_lvl[0];
    assign ref_tick = (pin_s2[1] == pin_s3[1]) && pin_s3[1] && !pin_lvl[1];

    assign iso_wr = reg_req.wr && (reg_req.addr == `PTP_ADDR_ISO_CTRL);
    assign proto  = ptp_proto_e'(iso_ctrl[`PTP_PROTO_LSB +: 3]);

    always_comb
    begin
        case (proto)
            PTP_P15693_LO,
            PTP_P15693_HI: proto_pulse = 8'(`PTP_NS10_TO_REF(`PTP_PULSE_15693_NS10));
            PTP_A106:      proto_pulse = 8'(`PTP_NS10_TO_REF(`PTP_PULSE_A106_NS10));
            PTP_A212:      proto_pulse = 8'(`PTP_NS10_TO_REF(`PTP_PULSE_A212_NS10));
            PTP_A424:      proto_pulse = 8'(`PTP_NS10_TO_REF(`PTP_PULSE_A424_NS10));
            PTP_A848:      proto_pulse = 8'(`PTP_NS10_TO_REF(`PTP_PULSE_A848_NS10));
            default:       proto_pulse = 8'h00;
        endcase
    end

    // no-response preset for the protocol being written
    always_comb
    begin
        case (ptp_proto_e'(reg_req.wdata[`PTP_PROTO_LSB +: 3]))
            PTP_P15693_LO: proto_no_reply_timeout_bits = 8'(`PTP_US100_TO_NR(`PTP_NR_15693LO_US100));
            PTP_P15693_HI: proto_no_reply_timeout_bits = 8'(`PTP_US100_TO_NR(`PTP_NR_15693HI_US100));
            default:       proto_no_reply_timeout_bits = 8'(`PTP_US100_TO_NR(`PTP_NR_OTHER_US100));
        endcase
    end

    assign pulse_len = ((tx_pulse != 8'h00) && (proto != PTP_A848)) ? tx_pulse : proto_pulse;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            iso_ctrl <= `PTP_RST_ISO_CTRL;
        else if (ce)
        begin
            if (!en_ok)
                iso_ctrl <= `PTP_RST_ISO_CTRL;
            else if (iso_wr)
                iso_ctrl <= reg_req.wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            tx_pulse <= `PTP_RST_TX_PULSE;
        else if (ce)
        begin
            if (!en_ok || iso_wr)
                tx_pulse <= `PTP_RST_TX_PULSE;
            else if (reg_req.wr && (reg_req.addr == `PTP_ADDR_TX_PULSE))
                tx_pulse <= reg_req.wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            no_reply_timeout_bits <= `PTP_RST_NO_REPLY_TIMEOUT_BITS;
        else if (ce)
        begin
            if (!en_ok)
                no_reply_timeout_bits <= `PTP_RST_NO_REPLY_TIMEOUT_BITS;
            else if (iso_wr)
                no_reply_timeout_bits <= proto_no_reply_timeout_bits;
            else if (reg_req.wr && (reg_req.addr == `PTP_ADDR_NO_REPLY_TIMEOUT_BITS))
                no_reply_timeout_bits <= reg_req.wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            tmr_len <= `PTP_RST_TMR;
        else if (ce)
        begin
            if (!en_ok || iso_wr)
                tmr_len <= `PTP_RST_TMR;
            else if (reg_req.wr && (reg_req.addr == `PTP_ADDR_TMR_HI))
                tmr_len[13:8] <= reg_req.wdata[5:0];
            else if (reg_req.wr && (reg_req.addr == `PTP_ADDR_TMR_LO))
                tmr_len[7:0] <= reg_req.wdata;
        end
    end

    assign nr_arm = (nr_state == PTP_NR_IDLE) && slot_start && (no_reply_timeout_bits != 8'h00)
                    && ((proto == PTP_P15693_LO) || (proto == PTP_P15693_HI));

    always_comb
    begin
        case (nr_state)
            PTP_NR_IDLE:  next_nr_state = nr_arm ? PTP_NR_WAIT : PTP_NR_IDLE;
            PTP_NR_WAIT:
            begin
                if (rx_start || !en_ok || iso_wr)
                    next_nr_state = PTP_NR_IDLE;
                else if (nr_done)
                    next_nr_state = PTP_NR_FIRED;
                else
                    next_nr_state = PTP_NR_WAIT;
            end
            PTP_NR_FIRED: next_nr_state = PTP_NR_IDLE;
            default:      next_nr_state = PTP_NR_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            nr_state <= PTP_NR_IDLE;
        else if (ce)
            nr_state <= next_nr_state;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            no_reply_timeout_bits_flag <= 1'b0;
        else if (ce)
        begin
            if (nr_state == PTP_NR_FIRED)
                no_reply_timeout_bits_flag <= 1'b1;
            else if (!en_ok || (reg_req.rd && (reg_req.addr == `PTP_ADDR_IRQ_STAT)))
                no_reply_timeout_bits_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (ce && reg_req.rd)
        begin
            case (reg_req.addr)
                `PTP_ADDR_ISO_CTRL:  reg_rdata <= iso_ctrl;
                `PTP_ADDR_TMR_HI:    reg_rdata <= {2'h0, tmr_len[13:8]};
                `PTP_ADDR_TMR_LO:    reg_rdata <= tmr_len[7:0];
                `PTP_ADDR_TX_PULSE:  reg_rdata <= tx_pulse;
                `PTP_ADDR_NO_REPLY_TIMEOUT_BITS:    reg_rdata <= no_reply_timeout_bits;
                `PTP_ADDR_IRQ_STAT:  reg_rdata <= 8'(no_reply_timeout_bits_flag) << `PTP_NO_REPLY_TIMEOUT_BITS_FLAG_BIT;
                default:             reg_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mod_pulse  <= 1'b0;
            irq        <= 1'b0;
            timer_done <= 1'b0;
        end
        else if (ce)
        begin
            mod_pulse  <= pulse_busy;
            irq        <= no_reply_timeout_bits_flag || (nr_state == PTP_NR_FIRED);
            timer_done <= tmr_done_w;
        end
    end

    ptp_step_timer u_pulse (
        .clk      (core_clk),
        .rst      (rst),
        .ce       (ce),
        .tick     (ref_tick),
        .start    (mod_req && !pulse_busy),
        .stop     (!en_ok),
        .steps    ({6'h00, pulse_len}),
        .prescale (10'h001),
        .busy     (pulse_busy),
        .done     ()
    );

    ptp_step_timer u_no_reply_timeout_bits (
        .clk      (core_clk),
        .rst      (rst),
        .ce       (ce),
        .tick     (ref_tick),
        .start    (nr_arm),
        .stop     (next_nr_state == PTP_NR_IDLE),
        .steps    ({6'h00, no_reply_timeout_bits}),
        .prescale (10'(`PTP_NO_REPLY_TIMEOUT_BITS_STEP_REF)),
        .busy     (),
        .done     (nr_done)
    );

    ptp_step_timer u_tmr (
        .clk      (core_clk),
        .rst      (rst),
        .ce       (ce),
        .tick     (ref_tick),
        .start    (timer_start),
        .stop     (!en_ok),
        .steps    (tmr_len),
        .prescale (10'(`PTP_TMR_STEP_REF)),
        .busy     (),
        .done     (tmr_done_w)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_ISO_CLEARS_PULSE: assert property (ce && en_ok && iso_wr |=> tx_pulse == 8'h00)
        else $error("pulse register not cleared by protocol write");
    AST_EN_LOW_PRESET: assert property (
        ce && !en_ok |=> no_reply_timeout_bits == 8'h0e && tx_pulse == 8'h00)
        else $error("registers not preset while disabled");
    AST_ZERO_USES_PROTO: assert property (tx_pulse == 8'h00 |-> pulse_len == proto_pulse)
        else $error("zero override altered pulse length");
    AST_OVERRIDE_LEN: assert property (
        tx_pulse != 8'h00 && proto != PTP_A848 |-> pulse_len == tx_pulse)
        else $error("override length not applied");
    AST_848_NO_OVERRIDE: assert property (proto == PTP_A848 |-> pulse_len == 8'd6)
        else $error("848 kbps pulse length wrong");
    AST_LO_PRESET: assert property (
        ce && en_ok && iso_wr && reg_req.wdata[2:0] == 3'h0 |=> no_reply_timeout_bits == 8'd48)
        else $error("15693 low rate preset wrong");
    AST_ONLY_15693: assert property (
        nr_state == PTP_NR_WAIT |-> proto inside {PTP_P15693_LO, PTP_P15693_HI})
        else $error("no-response timer ran outside 15693");
    AST_FIRE_FLAG: assert property (ce && nr_state == PTP_NR_FIRED |=> no_reply_timeout_bits_flag && irq)
        else $error("timeout did not set flag and irq");
    AST_STOP_ON_RX: assert property (
        ce && nr_state == PTP_NR_WAIT && rx_start |=> nr_state == PTP_NR_IDLE)
        else $error("response did not stop timer");
    AST_ISO_CLEARS_TMR: assert property (ce && en_ok && iso_wr |=> tmr_len == 14'h0000)
        else $error("timer length not preset");

    COV_TIMEOUT: cover property (nr_state == PTP_NR_WAIT ##1 nr_state == PTP_NR_FIRED);
    COV_RESPONSE: cover property (nr_state == PTP_NR_WAIT && rx_start);
    COV_OVERRIDE_PULSE: cover property (mod_pulse && tx_pulse != 8'h00);
    COV_TIMER_DONE: cover property (timer_done);

endmodule

/* sim/ptp_host_model.sv */
module ptp_host_model
    import ptp_pkg::*;
(
    input  wire logic       clk,
    output ptp_reg_req_s    reg_req,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial reg_req = '0;

    // one-cycle write strobe, released at the next edge
    task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '0;
    endtask

    // read data is held until the next read, so sample late
    task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        reg_req <= '0;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask
endmodule

/* sim/tb_protocol_timing_param_regs.sv */
`include "ptp_params.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end

module tb_protocol_timing_param_regs
    import ptp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic         core_clk, rst, ce, chip_en, ref_clk_in;
    logic         mod_req, slot_start, rx_start, timer_start;
    ptp_reg_req_s reg_req;
    logic [7:0]   reg_rdata, rd;
    logic         mod_pulse, irq, timer_done;
    int           fail_count, comparisons, ticks, k, t0;
    int           seed = 32'ha097;
    int           exp_reg[int];
    int           protos[$] = '{0, 1, 2, 3, 4, 5, 7};
    int           pulse_ns[$] = '{9440, 9440, 2360, 1400, 737, 442, 0};
    int           nr_us[$] = '{1812, 755, 529, 529, 529, 529, 529};

    ptp_timing_regs dut (
        .core_clk    (core_clk),
        .rst         (rst),
        .ce          (ce),
        .chip_en     (chip_en),
        .ref_clk_in  (ref_clk_in),
        .reg_req     (reg_req),
        .mod_req     (mod_req),
        .slot_start  (slot_start),
        .rx_start    (rx_start),
        .timer_start (timer_start),
        .reg_rdata   (reg_rdata),
        .mod_pulse   (mod_pulse),
        .irq         (irq),
        .timer_done  (timer_done)
    );

    ptp_host_model host (
        .clk       (core_clk),
        .reg_req   (reg_req),
        .reg_rdata (reg_rdata)
    );

    initial
    begin
        core_clk = 0;
        forever #2 core_clk = ~core_clk;
    end

    // reference clock unrelated in phase to the core clock
    initial
    begin
        ref_clk_in = 0;
        forever #18.4 ref_clk_in = ~ref_clk_in;
    end

    always @(posedge ref_clk_in) ticks++;

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #400000;
        fail_count++;
        end_of_test();
    end

    // model of the presets applied on reset, disable and protocol write
    task automatic model_preset(input int i);
        exp_reg[4] = 0;
        exp_reg[5] = 0;
        exp_reg[6] = 0;
        exp_reg[7] = (nr_us[i] * 100 + 1888) / 3776;
    endtask

    task automatic chk_regs();
        foreach (exp_reg[a])
        begin
            host.read_reg(5'(a), rd);
            `CHK(rd, 8'(exp_reg[a]))
        end
    endtask

    task automatic set_proto(input int i);
        host.write_reg(`PTP_ADDR_ISO_CTRL, 8'(protos[i]));
        model_preset(i);
    endtask

    task automatic wr(input int a, input int d);
        host.write_reg(5'(a), 8'(d));
        exp_reg[a] = d;
    endtask

    task automatic strobe(input int which);
        @(posedge core_clk);
        case (which)
            0: mod_req <= 1'b1;
            1: slot_start <= 1'b1;
            2: rx_start <= 1'b1;
            default: timer_start <= 1'b1;
        endcase
        @(posedge core_clk);
        {mod_req, slot_start, rx_start, timer_start} <= 4'h0;
    endtask

    // count reference ticks that the pulse spans
    task automatic check_pulse(input int n);
        strobe(0);
        for (k = 0; k < 20 && mod_pulse !== 1'b1; k++) @(negedge core_clk);
        t0 = ticks;
        for (k = 0; k < 3000 && mod_pulse === 1'b1; k++) @(negedge core_clk);
        `CHK(ticks - t0 >= n - 1 && ticks - t0 <= n + 1, 1'b1)
    endtask

    // wait for irq within a bound, elapsed ticks left as ticks - t0
    task automatic wait_irq(input int lim);
        t0 = ticks;
        for (k = 0; k < lim && irq !== 1'b1; k++) @(negedge core_clk);
    endtask

    initial
    begin
        {rst, ce, chip_en} = 3'b110;
        {mod_req, slot_start, rx_start, timer_start} = 4'h0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        chip_en <= 1'b1;
        repeat (8) @(posedge core_clk);

        // reset values and an unmapped read
        model_preset(6);
        chk_regs();
        host.read_reg(5'h1f, rd);
        `CHK(rd, 8'h00)
        $display("test reset_values done");

        // random contents, then every protocol preset
        foreach (protos[i])
        begin
            wr(6, ($random(seed) & 8'hfe) | 1);
            wr(7, ($random(seed) & 8'hfe) | 1);
            wr(4, $random(seed) & 8'h3f);
            wr(5, $random(seed) & 8'hff);
            chk_regs();
            set_proto(i);
            chk_regs();
        end
        $display("test protocol_presets done");

        // default pulse per protocol, then override
        foreach (protos[i])
        begin
            set_proto(i);
            check_pulse((pulse_ns[i] * 10 + 368) / 737);
        end
        set_proto(2);
        wr(6, 5);
        check_pulse(5);
        wr(6, 255);
        check_pulse(255);
        set_proto(5);
        wr(6, 5);
        check_pulse(6);
        $display("test pulse_length done");

        // no-response timeout, one step
        set_proto(0);
        wr(7, 1);
        strobe(1);
        wait_irq(8000);
        `CHK(ticks - t0 >= 510 && ticks - t0 <= 514, 1'b1)
        `CHK(irq, 1'b1)
        host.read_reg(`PTP_ADDR_IRQ_STAT, rd);
        `CHK(rd[`PTP_NO_REPLY_TIMEOUT_BITS_FLAG_BIT], 1'b1)
        repeat (3) @(negedge core_clk);
        `CHK(irq, 1'b0)
        host.read_reg(`PTP_ADDR_IRQ_STAT, rd);
        `CHK(rd[`PTP_NO_REPLY_TIMEOUT_BITS_FLAG_BIT], 1'b0)
        // a response start stops the timer
        strobe(1);
        repeat (100) @(posedge core_clk);
        strobe(2);
        wait_irq(6000);
        `CHK(irq, 1'b0)
        // a non-15693 protocol (106 kbps) does not time out
        set_proto(2);
        wr(7, 1);
        strobe(1);
        wait_irq(6000);
        `CHK(irq, 1'b0)
        $display("test no_response done");

        // timer length 3 steps of 8 ticks, then zero disables
        wr(5, 3);
        strobe(3);
        t0 = ticks;
        for (k = 0; k < 1000 && timer_done !== 1'b1; k++) @(negedge core_clk);
        `CHK(ticks - t0 >= 23 && ticks - t0 <= 26, 1'b1)
        wr(5, 0);
        strobe(3);
        for (k = 0; k < 500 && timer_done !== 1'b1; k++) @(negedge core_clk);
        `CHK(timer_done, 1'b0)
        $display("test timer_length done");

        // clock enable low freezes register writes
        @(posedge core_clk);
        ce <= 1'b0;
        host.write_reg(`PTP_ADDR_TX_PULSE, 8'h5a);
        ce <= 1'b1;
        chk_regs();
        $display("test clock_enable done");

        // chip disable presets registers
        wr(6, 8'h33);
        wr(7, 8'h44);
        chip_en <= 1'b0;
        repeat (10) @(posedge core_clk);
        chip_en <= 1'b1;
        repeat (8) @(posedge core_clk);
        model_preset(6);
        chk_regs();
        $display("test chip_disable done");
        end_of_test();
    end
endmodule
